/* fwcal_coef_store.v */
// Calibration coefficient memory with one write and one registered read port
`default_nettype none

module fwcal_coef_store #(
   parameter WIDTH = 32,
   parameter DEPTH = 256,
   parameter AW = 8
)(
   input wire clk_sys,
   input wire sys_rst,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   input wire rd_en,
   input wire [AW-1:0] rd_addr,
   output wire rd_valid,
   output wire [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [WIDTH-1:0] rd_data_reg;
   reg rd_valid_reg;

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;

   always @(posedge clk_sys)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      if (rd_en)
         rd_data_reg <= mem[rd_addr];
   end

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rd_valid_reg <= 1'b0;
      else
         rd_valid_reg <= rd_en;
   end
endmodule // fwcal_coef_store

`default_nettype wire

/* fwcal_fifo.v */
// Synchronous FIFO with valid and ready on both sides and a flush
`default_nettype none

module fwcal_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
)(
   input wire clk_sys,
   input wire sys_rst,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   reg in_ready_reg;
   reg out_valid_reg;
   wire push;
   wire pop;

   assign push = in_valid && in_ready_reg;
   assign pop = out_ready && out_valid_reg;
   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = mem[rd_ptr_reg];

   always @*
   begin
      count_next = count_reg;
      if (push && !pop)
         count_next = count_reg + 1'b1;
      else if (pop && !push)
         count_next = count_reg - 1'b1;
   end

   always @(posedge clk_sys)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_reg <= 1'b1;
         out_valid_reg <= 1'b0;
      end
      else if (flush)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_reg <= 1'b1;
         out_valid_reg <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         count_reg <= count_next;
         in_ready_reg <= (count_next != DEPTH);
         out_valid_reg <= (count_next != {(AW+1){1'b0}});
      end
   end
endmodule // fwcal_fifo

`default_nettype wire

/* fwcal_regs.vh */
// Register offsets, field positions and counts of the update and calibration block
`ifndef FWCAL_REGS_VH
`define FWCAL_REGS_VH

`define FWCAL_OFF_UPDATE_CTRL 8'h48
`define FWCAL_OFF_COUNT_HIGH 8'h49
`define FWCAL_OFF_COUNT_LOW 8'h4a
`define FWCAL_OFF_PAYLOAD 8'h4b
`define FWCAL_OFF_SOURCE_SEL 8'h4f
`define FWCAL_OFF_CALIBRATION_DATA_WINDOW 8'h50
`define FWCAL_OFF_CALIBRATION_READ_SUBADDR 8'h54
`define FWCAL_OFF_CALIBRATION_WRITE_SUBADDR 8'h55
`define FWCAL_OFF_SETUP_CTRL 8'h60
`define FWCAL_OFF_NEXT_HIGH 8'h61
`define FWCAL_OFF_NEXT_LOW 8'h62
`define FWCAL_OFF_DOWNLOAD 8'h63

`define FWCAL_BIT_START 7
`define FWCAL_BIT_STOP 6
`define FWCAL_BIT_FULL 5
`define FWCAL_BIT_LOCK 4
`define FWCAL_BIT_SWITCH 3
`define FWCAL_BIT_BANK 2
`define FWCAL_BIT_ERROR 1
`define FWCAL_BIT_SUM_OK 0

`define FWCAL_IMAGE_BYTES 16'he000
`define FWCAL_LAST_BYTE 16'hdfff
`define FWCAL_SUM_GOOD 8'h00
`define FWCAL_SOURCE_RESET 2'h0
`define FWCAL_UNMAPPED_READ 8'h00

`endif

/* fwcal_store_model.sv */
// Behavioural image bank store with a stall control
`default_nettype none
module fwcal_store_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic img_valid,
   input wire logic [15:0] img_addr,
   input wire logic [7:0] img_data,
   output wire logic img_ready,
   output logic [16:0] got_n,
   output logic [7:0] got_sum,
   output logic got_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   assign img_ready = !stall;
   // Sum restarts with each image's first byte
   always @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
      begin
         got_n <= 17'h00000;
         got_sum <= 8'h00;
         got_bad <= 1'b0;
      end
      else if (img_valid && img_ready)
      begin
         got_n <= got_n + 17'h00001;
         got_sum <= (img_addr == 16'h0000) ? img_data : got_sum + img_data;
         got_bad <= got_bad | (img_data != img_addr[7:0]);
      end
endmodule // fwcal_store_model
`default_nettype wire

/* fwcal_top.v */
// Firmware update, source select and calibration window register block
//
// Overview of operation
// - Setting start in the update control register arms byte reception.
// - Writing stop in the update control register returns the machine to idle.
// - Update control bit 5 reads one once the whole image arrived.
// - Lock bit keeps the current bank for the next start.
// - Writing switch in the update control register swaps the active bank once a full image checks good.
// - Update control bit 2 reads one while bank one is active.
// - Update control bit 1 flags an error during an update.
// - Update control bit 0 reports the other bank's checksum valid.
// - Received byte count is sixteen bits, high and low bytes, reset zero.
// - A payload write while receiving with room in the FIFO delivers one image byte; other payload writes set the error bit.
// - Two-bit selector picks master, first or second slave; resets to master.
// - Four byte registers form a 32-bit read/write calibration window.
// - Writing a read sub-address loads that coefficient into the window.
// - Writing a write sub-address stores the window at that sub-address.
// - Setup start bit begins an update and clears itself.
// - Next-address registers show the byte expected next, readable anytime.
// - Setup stop bit aborts the update and clears itself.
// - Setup bit 5 reads one after the whole image, zero from reset.
// - Setup toggle bit requests a partition switch and clears itself.
// - Switch only when the image checks good; otherwise keep the old bank.
`default_nettype none
`include "fwcal_regs.vh"

module fwcal_top #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3,
   parameter COEF_DEPTH = 256,
   parameter COEF_AW = 8
)(
   input wire clk_sys,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   output wire payload_ready,
   output wire img_valid,
   output wire [15:0] img_addr,
   output wire [7:0] img_data,
   input wire img_ready,
   output wire [1:0] source_device_select,
   output wire first_bank_active,
   output wire lock_bank,
   output wire reboot_pulse
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_RECV = 2'b01;
   localparam [1:0] ST_FULL = 2'b10;

   function hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [15:0] count_reg;
   reg [7:0] sum_reg;
   reg error_reg;
   reg lock_reg;
   reg bank_reg;
   reg reboot_reg;
   reg [7:0] payload_reg;
   reg [1:0] source_reg;
   reg [2:0] setup_pulse_reg;
   reg [7:0] rd_sub_reg;
   reg [7:0] wr_sub_reg;
   reg [7:0] window_reg [0:3];
   reg [7:0] rdata_reg;
   reg [7:0] rdata_next;
   reg img_valid_reg;
   reg [15:0] img_addr_reg;
   reg [7:0] img_data_reg;
   reg [15:0] drain_cnt_reg;

   wire wr_ctrl;
   wire wr_setup;
   wire wr_payload;
   wire begin_cmd;
   wire abort_cmd;
   wire switch_cmd;
   wire full_image;
   wire sum_ok;
   wire accept;
   wire rejected;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire drain_ready;
   wire pop;
   wire coef_rd_en;
   wire coef_wr_en;
   wire coef_rd_valid;
   wire [31:0] coef_rd_data;
   wire [31:0] window_word;

   assign wr_ctrl = reg_wr && hit(reg_addr, `FWCAL_OFF_UPDATE_CTRL);
   assign wr_setup = reg_wr && hit(reg_addr, `FWCAL_OFF_SETUP_CTRL);
   assign wr_payload = reg_wr && (hit(reg_addr, `FWCAL_OFF_PAYLOAD) ||
      hit(reg_addr, `FWCAL_OFF_DOWNLOAD));
   assign begin_cmd = (wr_ctrl || wr_setup) && reg_wdata[`FWCAL_BIT_START];
   assign abort_cmd = (wr_ctrl || wr_setup) && reg_wdata[`FWCAL_BIT_STOP];
   assign switch_cmd = (wr_ctrl || wr_setup) && reg_wdata[`FWCAL_BIT_SWITCH];
   assign full_image = (state_reg == ST_FULL);
   assign sum_ok = full_image && (sum_reg == `FWCAL_SUM_GOOD);
   assign accept = wr_payload && (state_reg == ST_RECV) && fifo_in_ready;
   assign rejected = wr_payload && !accept;

   // Next state: abort beats start, start beats a completed image
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (begin_cmd)
               state_next = ST_RECV;
         end
         ST_RECV:
         begin
            if (accept && count_reg == `FWCAL_LAST_BYTE)
               state_next = ST_FULL;
         end
         ST_FULL:
         begin
            if (switch_cmd && sum_ok)
               state_next = ST_IDLE;
            else if (begin_cmd)
               state_next = ST_RECV;
         end
         default:
            state_next = ST_IDLE;
      endcase
      if (abort_cmd)
         state_next = ST_IDLE;
   end

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
         count_reg <= 16'h0000;
         sum_reg <= 8'h00;
         error_reg <= 1'b0;
         payload_reg <= 8'h00;
         setup_pulse_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (begin_cmd || abort_cmd)
         begin
            count_reg <= 16'h0000;
            sum_reg <= 8'h00;
         end
         else if (accept)
         begin
            count_reg <= count_reg + 16'h0001;
            sum_reg <= sum_reg + reg_wdata;
         end
         // A new event outranks the clear that start brings
         if (rejected || (switch_cmd && !sum_ok))
            error_reg <= 1'b1;
         else if (begin_cmd)
            error_reg <= 1'b0;
         if (wr_payload)
            payload_reg <= reg_wdata;
         // Setup command bits read back for one cycle, then clear
         if (wr_setup)
            setup_pulse_reg <= {reg_wdata[`FWCAL_BIT_START], reg_wdata[`FWCAL_BIT_STOP],
               reg_wdata[`FWCAL_BIT_SWITCH]};
         else
            setup_pulse_reg <= 3'h0;
      end
   end

   // Bank control and reboot request
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lock_reg <= 1'b0;
         bank_reg <= 1'b1;
         reboot_reg <= 1'b0;
         source_reg <= `FWCAL_SOURCE_RESET;
      end
      else
      begin
         if (wr_ctrl)
            lock_reg <= reg_wdata[`FWCAL_BIT_LOCK];
         if (switch_cmd && sum_ok)
            bank_reg <= ~bank_reg;
         reboot_reg <= switch_cmd && sum_ok;
         if (reg_wr && hit(reg_addr, `FWCAL_OFF_SOURCE_SEL))
            source_reg <= reg_wdata[1:0];
      end
   end

   fwcal_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .flush(begin_cmd || abort_cmd),
      .in_valid(accept),
      .in_ready(fifo_in_ready),
      .in_data(reg_wdata),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready),
      .out_data(fifo_out_data)
   );

   assign drain_ready = !img_valid_reg || img_ready;
   assign pop = fifo_out_valid && drain_ready;

   // Image bytes toward the spare bank store
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         img_valid_reg <= 1'b0;
         img_addr_reg <= 16'h0000;
         img_data_reg <= 8'h00;
         drain_cnt_reg <= 16'h0000;
      end
      else if (begin_cmd || abort_cmd)
      begin
         img_valid_reg <= 1'b0;
         drain_cnt_reg <= 16'h0000;
      end
      else if (pop)
      begin
         img_valid_reg <= 1'b1;
         img_addr_reg <= drain_cnt_reg;
         img_data_reg <= fifo_out_data;
         drain_cnt_reg <= drain_cnt_reg + 16'h0001;
      end
      else if (img_ready)
         img_valid_reg <= 1'b0;
   end

   // Calibration window and sub-address registers
   assign coef_rd_en = reg_wr && hit(reg_addr, `FWCAL_OFF_CALIBRATION_READ_SUBADDR);
   assign coef_wr_en = reg_wr && hit(reg_addr, `FWCAL_OFF_CALIBRATION_WRITE_SUBADDR);
   assign window_word = {window_reg[3], window_reg[2], window_reg[1], window_reg[0]};

   fwcal_coef_store #(
      .WIDTH(32),
      .DEPTH(COEF_DEPTH),
      .AW(COEF_AW)
   ) u_coef (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .wr_en(coef_wr_en),
      .wr_addr(reg_wdata[COEF_AW-1:0]),
      .wr_data(window_word),
      .rd_en(coef_rd_en),
      .rd_addr(reg_wdata[COEF_AW-1:0]),
      .rd_valid(coef_rd_valid),
      .rd_data(coef_rd_data)
   );

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_sub_reg <= 8'h00;
         wr_sub_reg <= 8'h00;
      end
      else
      begin
         if (coef_rd_en)
            rd_sub_reg <= reg_wdata;
         if (coef_wr_en)
            wr_sub_reg <= reg_wdata;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_window
         localparam [31:0] OFF_WIDE = `FWCAL_OFF_CALIBRATION_DATA_WINDOW + gi;
         localparam [7:0] BYTE_OFF = OFF_WIDE[7:0];
         always @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
               window_reg[gi] <= 8'h00;
            else if (coef_rd_valid)
               window_reg[gi] <= coef_rd_data[8*gi+7:8*gi];
            else if (reg_wr && hit(reg_addr, BYTE_OFF))
               window_reg[gi] <= reg_wdata;
         end
      end
   endgenerate

   // Register read mux
   always @*
   begin
      rdata_next = `FWCAL_UNMAPPED_READ;
      case (reg_addr)
         `FWCAL_OFF_UPDATE_CTRL:
            rdata_next = {state_reg != ST_IDLE, 1'b0, full_image, lock_reg, 1'b0,
               bank_reg, error_reg, sum_ok};
         `FWCAL_OFF_COUNT_HIGH:
            rdata_next = count_reg[15:8];
         `FWCAL_OFF_COUNT_LOW:
            rdata_next = count_reg[7:0];
         `FWCAL_OFF_PAYLOAD:
            rdata_next = payload_reg;
         `FWCAL_OFF_DOWNLOAD:
            rdata_next = payload_reg;
         `FWCAL_OFF_SOURCE_SEL:
            rdata_next = {6'h00, source_reg};
         `FWCAL_OFF_CALIBRATION_DATA_WINDOW:
            rdata_next = window_reg[0];
         `FWCAL_OFF_CALIBRATION_DATA_WINDOW + 8'h01:
            rdata_next = window_reg[1];
         `FWCAL_OFF_CALIBRATION_DATA_WINDOW + 8'h02:
            rdata_next = window_reg[2];
         `FWCAL_OFF_CALIBRATION_DATA_WINDOW + 8'h03:
            rdata_next = window_reg[3];
         `FWCAL_OFF_CALIBRATION_READ_SUBADDR:
            rdata_next = rd_sub_reg;
         `FWCAL_OFF_CALIBRATION_WRITE_SUBADDR:
            rdata_next = wr_sub_reg;
         `FWCAL_OFF_SETUP_CTRL:
            rdata_next = {setup_pulse_reg[2], setup_pulse_reg[1], full_image, 1'b0,
               setup_pulse_reg[0], 3'h0};
         `FWCAL_OFF_NEXT_HIGH:
            rdata_next = count_reg[15:8];
         `FWCAL_OFF_NEXT_LOW:
            rdata_next = count_reg[7:0];
         default:
            rdata_next = `FWCAL_UNMAPPED_READ;
      endcase
   end

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_reg <= 8'h00;
      else if (reg_rd)
         rdata_reg <= rdata_next;
   end

   assign reg_rdata = rdata_reg;
   assign payload_ready = fifo_in_ready;
   assign img_valid = img_valid_reg;
   assign img_addr = img_addr_reg;
   assign img_data = img_data_reg;
   assign source_device_select = source_reg;
   assign first_bank_active = bank_reg;
   assign lock_bank = lock_reg;
   assign reboot_pulse = reboot_reg;
endmodule // fwcal_top

`default_nettype wire

/* fwcal_top_props.sv */
// Port-level checker for the update and calibration register block
`default_nettype none
module fwcal_top_props (
   input wire clk_sys,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire payload_ready,
   input wire img_valid,
   input wire [15:0] img_addr,
   input wire [7:0] img_data,
   input wire img_ready,
   input wire [1:0] source_device_select,
   input wire first_bank_active,
   input wire lock_bank,
   input wire reboot_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   wire logic wr_ctl = reg_wr && (reg_addr == 8'h48 || reg_addr == 8'h60);
   wire logic wr_sel = reg_wr && reg_addr == 8'h4f;
   wire logic sw_req = wr_ctl && reg_wdata[3];
   logic [15:0] next_addr_reg;
   // Address the store should see next; restarts on start or stop
   always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
         next_addr_reg <= 16'h0000;
      else if (wr_ctl && (reg_wdata[7] || reg_wdata[6]))
         next_addr_reg <= 16'h0000;
      else if (img_valid && img_ready)
         next_addr_reg <= img_addr + 16'h0001;
   sequence s_reboot;
      reboot_pulse ##1 !reboot_pulse;
   endsequence
   property p_sel_wr;
      wr_sel |=> source_device_select == $past(reg_wdata[1:0]);
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("selector not loaded");
   property p_sel_hold;
      !wr_sel |=> $stable(source_device_select);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("selector moved");
   property p_sel_read;
      reg_rd && reg_addr == 8'h4f |=> reg_rdata == {6'h00, $past(source_device_select)};
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("selector readback");
   property p_lock_wr;
      reg_wr && reg_addr == 8'h48 |=> lock_bank == $past(reg_wdata[4]);
   endproperty
   a_lock_wr: assert property (p_lock_wr) else $error("lock not loaded");
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_img_hold;
      img_valid && !img_ready && !wr_ctl |=> img_valid && $stable(img_addr) && $stable(img_data);
   endproperty
   a_img_hold: assert property (p_img_hold) else $error("image byte dropped");
   property p_img_order;
      img_valid |-> img_addr == next_addr_reg;
   endproperty
   a_img_order: assert property (p_img_order) else $error("image address order");
   property p_bank_change;
      $changed(first_bank_active) |-> s_reboot;
   endproperty
   a_bank_change: assert property (p_bank_change) else $error("bank moved alone");
   property p_pulse;
      reboot_pulse |-> $past(sw_req);
   endproperty
   a_pulse: assert property (p_pulse) else $error("reboot without request");
endmodule // fwcal_top_props

bind fwcal_top fwcal_top_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .payload_ready(payload_ready), .img_valid(img_valid),
   .img_addr(img_addr), .img_data(img_data), .img_ready(img_ready),
   .source_device_select(source_device_select), .first_bank_active(first_bank_active),
   .lock_bank(lock_bank), .reboot_pulse(reboot_pulse));
`default_nettype wire

/* test_fwcal_top.sv */
// Testbench for the update and calibration register block
`default_nettype none
module test_fwcal_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic stall = 1'b0;
   wire logic [7:0] reg_rdata, img_data, got_sum;
   wire logic payload_ready, img_valid, img_ready, first_bank_active, lock_bank;
   wire logic reboot_pulse, got_bad;
   wire logic [15:0] img_addr;
   wire logic [1:0] source_device_select;
   wire logic [16:0] got_n;
   int num_errors = 0;
   int n_tests = 0;
   int sent;
   int n0;
   logic [7:0] v;
   always #5 clk_sys = ~clk_sys;
   fwcal_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .payload_ready(payload_ready), .img_valid(img_valid), .img_addr(img_addr),
      .img_data(img_data), .img_ready(img_ready), .source_device_select(source_device_select),
      .first_bank_active(first_bank_active), .lock_bank(lock_bank),
      .reboot_pulse(reboot_pulse));
   fwcal_store_model u_store (.clk_sys(clk_sys), .sys_rst(sys_rst), .stall(stall),
      .img_valid(img_valid), .img_addr(img_addr), .img_data(img_data),
      .img_ready(img_ready), .got_n(got_n), .got_sum(got_sum), .got_bad(got_bad));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   // Payload bytes back to back, data equal to the low byte of the byte index, only while ready
   task automatic stream(input int n, input int lim);
      sent = 0;
      for (int k = 0; k < lim && sent < n; k++)
      begin
         @(negedge clk_sys);
         reg_addr = 8'h4b;
         reg_wdata = sent[7:0];
         reg_wr = (payload_ready === 1'b1);
         if (payload_ready === 1'b1)
            sent++;
      end
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic drain;
      for (int k = 0; k < 50 && got_n - n0 != sent; k++)
         @(negedge clk_sys);
   endtask
   task automatic t_reset;
      chk("bank pin", first_bank_active, 1);
      chk("select pin", source_device_select, 0);
      rd(8'h48);
      chk("control", v & 8'hfe, 8'h04);
      rd(8'h49);
      chk("count high", v, 0);
      rd(8'h60);
      chk("setup", v, 0);
      rd(8'h40);
      chk("unmapped", v, 0);
      $display("test reset done");
   endtask
   task automatic t_select_lock;
      for (int s = 0; s < 3; s++)
      begin
         wr(8'h4f, s[7:0]);
         chk("select pin", source_device_select, s);
         rd(8'h4f);
         chk("select reg", v, s);
      end
      wr(8'h4f, 8'h00);
      wr(8'h48, 8'h10);
      chk("lock pin", lock_bank, 1);
      rd(8'h48);
      chk("lock bit", v[4], 1);
      wr(8'h48, 8'h00);
      chk("lock pin", lock_bank, 0);
      $display("test select and lock done");
   endtask
   task automatic t_coef;
      for (int b = 0; b < 4; b++)
         wr(8'h50 + b[7:0], 8'h11 + 8'h11 * b[7:0]);
      rd(8'h52);
      chk("window byte", v, 8'h33);
      wr(8'h55, 8'h05);
      for (int b = 0; b < 4; b++)
         wr(8'h50 + b[7:0], 8'h00);
      wr(8'h54, 8'h05);
      repeat (2) @(negedge clk_sys);
      for (int b = 0; b < 4; b++)
      begin
         rd(8'h50 + b[7:0]);
         chk("loaded window", v, 8'h11 + 8'h11 * b[7:0]);
      end
      rd(8'h54);
      chk("read sub", v, 8'h05);
      $display("test calibration done");
   endtask
   task automatic t_bad_switch;
      wr(8'h60, 8'h80);
      stream(3, 10);
      rd(8'h4a);
      chk("count low", v, 3);
      rd(8'h62);
      chk("next low", v, 3);
      rd(8'h61);
      chk("next high", v, 0);
      wr(8'h60, 8'h08);
      chk("no reboot", reboot_pulse, 0);
      repeat (3) @(negedge clk_sys);
      chk("bank kept", first_bank_active, 1);
      rd(8'h48);
      chk("error bit", v[1], 1);
      wr(8'h48, 8'h40);
      rd(8'h4a);
      chk("count cleared", v, 0);
      rd(8'h48);
      chk("idle", v[7], 0);
      $display("test failed switch done");
   endtask
   task automatic t_stall;
      stall = 1'b1;
      n0 = got_n;
      wr(8'h48, 8'h80);
      rd(8'h48);
      chk("armed", v[7], 1);
      rd(8'h60);
      chk("start cleared", v[7], 0);
      stream(20, 40);
      chk("ready low", payload_ready, 0);
      rd(8'h4a);
      chk("count held", v, sent);
      stall = 1'b0;
      drain;
      chk("store got", got_n - n0, sent);
      chk("store data", got_bad, 0);
      stall = 1'b1;
      stream(2, 4);
      wr(8'h60, 8'h40);
      stall = 1'b0;
      rd(8'h4a);
      chk("aborted count", v, 0);
      rd(8'h60);
      chk("setup self clear", v & 8'he8, 0);
      $display("test stall and abort done");
   endtask
   task automatic t_full;
      n0 = got_n;
      wr(8'h60, 8'h80);
      stream(57344, 60000);
      drain;
      chk("store sum", got_sum, 0);
      rd(8'h60);
      chk("full setup", v[5], 1);
      rd(8'h48);
      chk("full control", v & 8'h23, 8'h21);
      rd(8'h61);
      chk("next high", v, 8'he0);
      rd(8'h49);
      chk("count high", v, 8'he0);
      wr(8'h60, 8'h08);
      for (int k = 0; k < 8 && first_bank_active !== 1'b0; k++)
         @(negedge clk_sys);
      chk("bank toggled", first_bank_active, 0);
      chk("reboot pulse", reboot_pulse, 1);
      @(negedge clk_sys);
      chk("reboot once", reboot_pulse, 0);
      rd(8'h48);
      chk("bank bit", v[2], 0);
      wr(8'h48, 8'h08);
      chk("idle no reboot", reboot_pulse, 0);
      rd(8'h48);
      chk("idle switch", v & 8'h26, 8'h02);
      $display("test full image done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #700000;
      num_errors++;
      wrap_up;
   end
   initial
   begin
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset;
      t_select_lock;
      t_coef;
      t_bad_switch;
      t_stall;
      t_full;
      wrap_up;
   end
endmodule // test_fwcal_top
`default_nettype wire
